/* File: hdl/drc_pkg.sv */
// package for the debug run-control block: register map, fields, constants
package drc_pkg;

  // ----------------------------------------------------------------------
  // apb register map (byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] CMD_OFF    = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] FLASH_OFF  = 8'h0C;
  localparam logic [7:0] WRAM_LO_OFF = 8'h10;
  localparam logic [7:0] WRAM_HI_OFF = 8'h14;
  localparam logic [7:0] PEND_OFF   = 8'h18;

  // cmd register bit positions (write-one pulses)
  localparam int CMD_BREAK  = 0;
  localparam int CMD_RUN    = 1;
  localparam int CMD_STEP   = 2;
  localparam int CMD_RESET  = 3;
  localparam int CMD_FLASH  = 4;
  localparam int CMD_SWRST  = 5;

  // ctrl register field positions
  localparam int CTRL_RSTMASK = 0;
  localparam int CTRL_CLKUP   = 1;
  localparam int CTRL_FLENA   = 2;
  localparam int CTRL_GUARD   = 3;
  localparam int CTRL_VAR_LSB = 4;
  localparam int CTRL_OSC_LSB = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0006;

  // flash-rewrite working RAM window
  localparam logic [31:0] WRAM_LO_RST = 32'hFEBF_DA00;
  localparam logic [31:0] WRAM_HI_RST = 32'hFEBF_FFFF;

  // timing
  localparam int SYS_CLK_HZ   = 25_000_000;
  localparam int LINK_HZ      = 20_000_000;
  localparam int RST_PULSE_NS = 200;
  localparam int RST_CYC = (RST_PULSE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] RST_CYC_W = 4'(RST_CYC);

  // device variant and oscillator codes
  typedef enum logic [1:0] {
    VAR_240 = 2'b00,
    VAR_200 = 2'b01,
    VAR_160 = 2'b10,
    VAR_120 = 2'b11
  } drc_var_e;

  typedef enum logic [1:0] {
    OSC_8  = 2'b00,
    OSC_10 = 2'b01,
    OSC_12 = 2'b10,
    OSC_16 = 2'b11
  } drc_osc_e;

  typedef enum logic [1:0] {
    ST_BREAK = 2'b00,
    ST_STEP  = 2'b01,
    ST_RUN   = 2'b10
  } drc_state_e;

  // cpu-facing control bundle
  typedef struct packed {
    logic core_reset;
    logic irq_mask;
    logic halt_allow;
    logic break_req;
    logic resume_at_reset;
  } drc_cpu_ctl_s;

  // debugger memory access request
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } drc_dacc_s;

endpackage : drc_pkg

/* File: hdl/drc_run_control.sv */
// debug run-control: state, reset/irq masking, step traps, access guards, flash clock
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
// Function
// - block user resets in break/step, pass in run
// - debugger reset always resets the cpu
// - after debugger reset all cores break
// - masked resets are dropped, never deferred
// - mask interrupts in break and step
// - masked interrupts stay pending until unmasked
// - entering break leaves halt condition
// - stepped halt breaks at next instruction
// - stepped deep stop breaks at reset address
// - debugger accesses pass same enable checks
// - bus guard blocks debugger, flags error
// - link at 20 MHz, events spaced apart
// - flash rewrite uses protected working ram
// - 240 MHz variant multiplier table
// - 200 MHz variant multiplier table
// - 160 MHz variant multiplier table
// - 120 MHz variant multiplier table
// - clock above monitor limit stops rewrite
module drc_run_control #(
  parameter int NCORE = 2
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     resetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // user-system reset and interrupt sources
  input  wire logic                     pin_reset_n,
  input  wire logic                     user_sw_reset,
  input  wire logic                     maskable_irq,
  input  wire logic                     fast_irq,
  input  wire logic                     float_exception_irq,
  // cpu status
  input  wire logic                     halt_exec,
  input  wire logic                     deep_power_stop,
  input  wire logic                     step_done,
  // debugger memory access
  input  wire logic                     dacc_valid,
  input  wire logic [31:0]              dacc_addr,
  input  wire logic                     dma_valid,
  input  wire logic [31:0]              dma_addr,
  input  wire logic                     clock_monitor_over,
  // cpu side
  output logic      [NCORE-1:0]         core_reset,
  output logic      [NCORE-1:0]         core_break,
  output logic                          irq_mask,
  output logic                          halt_mode,
  output logic                          resume_at_reset,
  output logic      [2:0]               irq_deliver,
  // access and flash control
  output logic                          dacc_grant,
  output logic                          guard_error,
  output logic                          dma_conflict,
  output logic      [5:0]               pll_mult_x2,
  output logic                          flash_clk_up,
  output logic                          flash_busy
);

  // ----------------------------------------------------------------------
  // pin synchronisers (3 stages, change counts once stages 2 and 3 agree)
  // ----------------------------------------------------------------------
  logic [2:0] pin_rst_sync_reg;
  logic       pin_rst_reg;
  logic [2:0] mon_sync_reg;
  logic       mon_over_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pin_rst_sync_reg <= 3'h7;
      pin_rst_reg      <= 1'b0;
      mon_sync_reg     <= 3'h0;
      mon_over_reg     <= 1'b0;
    end else begin
      pin_rst_sync_reg <= {pin_rst_sync_reg[1:0], pin_reset_n};
      mon_sync_reg     <= {mon_sync_reg[1:0], clock_monitor_over};
      if (pin_rst_sync_reg[1] == pin_rst_sync_reg[2])
        pin_rst_reg <= ~pin_rst_sync_reg[2];
      if (mon_sync_reg[1] == mon_sync_reg[2])
        mon_over_reg <= mon_sync_reg[2];
    end
  end

  // ----------------------------------------------------------------------
  // apb registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [31:0] wram_lo_reg;
  logic [31:0] wram_hi_reg;
  logic [5:0]  cmd_reg;
  logic        guard_err_reg;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;

  assign apb_wr  = psel && penable && pwrite;
  assign apb_rd  = psel && penable && !pwrite;
  assign addr_ok = (paddr == drc_pkg::CTRL_OFF) || (paddr == drc_pkg::CMD_OFF) ||
                   (paddr == drc_pkg::STATUS_OFF) || (paddr == drc_pkg::FLASH_OFF) ||
                   (paddr == drc_pkg::WRAM_LO_OFF) || (paddr == drc_pkg::WRAM_HI_OFF) ||
                   (paddr == drc_pkg::PEND_OFF);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_reg    <= drc_pkg::CTRL_RESET;
      wram_lo_reg <= drc_pkg::WRAM_LO_RST;
      wram_hi_reg <= drc_pkg::WRAM_HI_RST;
    end else if (apb_wr) begin
      // working ram window may be moved away from dma traffic
      unique case (paddr)
        drc_pkg::CTRL_OFF:    ctrl_reg    <= {24'h0, pwdata[7:0]};
        drc_pkg::WRAM_LO_OFF: wram_lo_reg <= pwdata;
        drc_pkg::WRAM_HI_OFF: wram_hi_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // command bits live one cycle; one pulse per transfer keeps link events apart
  always_ff @(posedge sys_clk) begin
    if (!resetn)
      cmd_reg <= 6'h00;
    else if (apb_wr && paddr == drc_pkg::CMD_OFF)
      cmd_reg <= pwdata[5:0];
    else
      cmd_reg <= 6'h00;
  end

  // ----------------------------------------------------------------------
  // run state
  // ----------------------------------------------------------------------
  drc_pkg::drc_state_e state_reg;
  logic [3:0]          dbg_rst_cnt_reg;
  logic                dbg_rst_reg;
  logic                halt_reg;
  logic                resume_rst_reg;
  logic                in_run;
  logic                user_rst;

  assign in_run   = (state_reg == drc_pkg::ST_RUN);
  // discarded outright outside run; no latch holds them
  assign user_rst = in_run && (pin_rst_reg || user_sw_reset || cmd_reg[drc_pkg::CMD_SWRST]);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dbg_rst_reg     <= 1'b0;
      dbg_rst_cnt_reg <= 4'h0;
    end else if (cmd_reg[drc_pkg::CMD_RESET]) begin
      dbg_rst_reg     <= 1'b1;
      dbg_rst_cnt_reg <= drc_pkg::RST_CYC_W;
    end else if (dbg_rst_cnt_reg != 4'h0) begin
      dbg_rst_cnt_reg <= dbg_rst_cnt_reg - 4'h1;
      dbg_rst_reg     <= (dbg_rst_cnt_reg != 4'h1);
    end else begin
      dbg_rst_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg      <= drc_pkg::ST_BREAK;
      resume_rst_reg <= 1'b0;
    end else if (dbg_rst_reg && dbg_rst_cnt_reg == 4'h1) begin
      state_reg      <= drc_pkg::ST_BREAK;
      resume_rst_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        drc_pkg::ST_BREAK: begin
          if (cmd_reg[drc_pkg::CMD_STEP])
            state_reg <= drc_pkg::ST_STEP;
          else if (cmd_reg[drc_pkg::CMD_RUN])
            state_reg <= drc_pkg::ST_RUN;
          resume_rst_reg <= 1'b0;
        end
        drc_pkg::ST_STEP: begin
          if (deep_power_stop) begin
            state_reg      <= drc_pkg::ST_BREAK;
            resume_rst_reg <= 1'b1;
          end else if (halt_exec || step_done || cmd_reg[drc_pkg::CMD_BREAK]) begin
            state_reg <= drc_pkg::ST_BREAK;
          end
        end
        drc_pkg::ST_RUN: begin
          if (cmd_reg[drc_pkg::CMD_BREAK])
            state_reg <= drc_pkg::ST_BREAK;
        end
        default: state_reg <= drc_pkg::ST_BREAK;
      endcase
    end
  end

  // halt condition only entered from run
  always_ff @(posedge sys_clk) begin
    if (!resetn)
      halt_reg <= 1'b0;
    else if (state_reg != drc_pkg::ST_RUN)
      halt_reg <= 1'b0;
    else if (halt_exec)
      halt_reg <= 1'b1;
    else if (irq_deliver != 3'h0)
      halt_reg <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // interrupt pending
  // ----------------------------------------------------------------------
  logic [2:0] pend_reg;
  logic [2:0] irq_in;
  logic       mask_now;

  assign irq_in   = {float_exception_irq, fast_irq, maskable_irq};
  assign mask_now = !in_run;

  always_ff @(posedge sys_clk) begin
    if (!resetn)
      pend_reg <= 3'h0;
    else if (mask_now)
      pend_reg <= pend_reg | irq_in;
    else
      pend_reg <= 3'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_deliver <= 3'h0;
      irq_mask    <= 1'b1;
    end else begin
      irq_mask    <= mask_now;
      irq_deliver <= mask_now ? 3'h0 : (pend_reg | irq_in);
    end
  end

  // ----------------------------------------------------------------------
  // cpu reset and break outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      core_reset      <= '0;
      core_break      <= '1;
      halt_mode       <= 1'b0;
      resume_at_reset <= 1'b0;
    end else begin
      core_reset      <= {NCORE{dbg_rst_reg || user_rst}};
      core_break      <= {NCORE{state_reg == drc_pkg::ST_BREAK}};
      halt_mode       <= halt_reg;
      resume_at_reset <= resume_rst_reg;
    end
  end

  // ----------------------------------------------------------------------
  // debugger access checks
  // ----------------------------------------------------------------------
  logic in_wram;
  logic in_flram;
  logic in_guard;

  // flash-ctrl ram and guard windows held as parameters of placement
  localparam logic [31:0] FLRAM_BASE = 32'hFFA1_0000;
  localparam logic [31:0] GUARD_BASE = 32'hFFC0_0000;
  assign in_flram = (dacc_addr[31:16] == FLRAM_BASE[31:16]);
  assign in_guard = (dacc_addr[31:16] == GUARD_BASE[31:16]);
  assign in_wram  = (dma_addr >= wram_lo_reg) && (dma_addr <= wram_hi_reg);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dacc_grant    <= 1'b0;
      guard_err_reg <= 1'b0;
      dma_conflict  <= 1'b0;
    end else begin
      dacc_grant <= dacc_valid &&
                    !(in_flram && !ctrl_reg[drc_pkg::CTRL_FLENA]) &&
                    !(in_guard && ctrl_reg[drc_pkg::CTRL_GUARD]);
      // set wins over clear
      if (dacc_valid && in_guard && ctrl_reg[drc_pkg::CTRL_GUARD])
        guard_err_reg <= 1'b1;
      else if (apb_wr && paddr == drc_pkg::STATUS_OFF && pwdata[0])
        guard_err_reg <= 1'b0;
      dma_conflict <= dma_valid && in_wram && flash_busy;
    end
  end
  assign guard_error = guard_err_reg;

  // ----------------------------------------------------------------------
  // flash rewrite clock raising
  // ----------------------------------------------------------------------
  logic [5:0] mult_sel;
  logic [1:0] var_sel;
  logic [1:0] osc_sel;

  assign var_sel = ctrl_reg[drc_pkg::CTRL_VAR_LSB +: 2];
  assign osc_sel = ctrl_reg[drc_pkg::CTRL_OSC_LSB +: 2];

  // multiplier times two so that 12.5 and 7.5 stay integral; 0 means unsupported
  always_comb begin
    mult_sel = 6'h00;
    unique case (var_sel)
      drc_pkg::VAR_240: mult_sel = (osc_sel == drc_pkg::OSC_8)  ? 6'h3C :
                                   (osc_sel == drc_pkg::OSC_10) ? 6'h30 :
                                   (osc_sel == drc_pkg::OSC_12) ? 6'h28 : 6'h1E;
      drc_pkg::VAR_200: mult_sel = (osc_sel == drc_pkg::OSC_8)  ? 6'h32 :
                                   (osc_sel == drc_pkg::OSC_10) ? 6'h28 :
                                   (osc_sel == drc_pkg::OSC_16) ? 6'h19 : 6'h00;
      drc_pkg::VAR_160: mult_sel = (osc_sel == drc_pkg::OSC_8)  ? 6'h28 :
                                   (osc_sel == drc_pkg::OSC_10) ? 6'h20 :
                                   (osc_sel == drc_pkg::OSC_16) ? 6'h14 : 6'h00;
      drc_pkg::VAR_120: mult_sel = (osc_sel == drc_pkg::OSC_8)  ? 6'h1E :
                                   (osc_sel == drc_pkg::OSC_10) ? 6'h18 :
                                   (osc_sel == drc_pkg::OSC_12) ? 6'h14 : 6'h0F;
    endcase
  end

  // rewrite starts on debugger command only, stops on a second command or a clock monitor trip
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_busy   <= 1'b0;
      flash_clk_up <= 1'b0;
      pll_mult_x2  <= 6'h00;
    end else if (flash_busy && (mon_over_reg || cmd_reg[drc_pkg::CMD_FLASH])) begin
      flash_busy   <= 1'b0;
      flash_clk_up <= 1'b0;
      pll_mult_x2  <= 6'h00;
    end else if (cmd_reg[drc_pkg::CMD_FLASH] && !mon_over_reg) begin
      flash_busy   <= 1'b1;
      flash_clk_up <= ctrl_reg[drc_pkg::CTRL_CLKUP] && (mult_sel != 6'h00);
      pll_mult_x2  <= ctrl_reg[drc_pkg::CTRL_CLKUP] ? mult_sel : 6'h00;
    end
  end

  // ----------------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= 32'h0;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          drc_pkg::CTRL_OFF:    prdata <= ctrl_reg;
          drc_pkg::STATUS_OFF:  prdata <= {20'h0, mult_sel, flash_busy, halt_reg,
                                           guard_err_reg, resume_rst_reg, state_reg};
          drc_pkg::FLASH_OFF:   prdata <= {24'h0, flash_clk_up, mon_over_reg, pll_mult_x2};
          drc_pkg::WRAM_LO_OFF: prdata <= wram_lo_reg;
          drc_pkg::WRAM_HI_OFF: prdata <= wram_hi_reg;
          drc_pkg::PEND_OFF:    prdata <= {29'h0, pend_reg};
          default:              prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule : drc_run_control
`default_nettype wire

/* File: bench/drc_rc_monitor.sv */
// port checker for the debug run-control block
`timescale 1ns/10ps
`default_nettype none
module drc_rc_monitor #(
  parameter int NCORE = 2
) (
  // clock and reset
  input wire logic             sys_clk,
  input wire logic             resetn,
  // apb side
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic             pready,
  // sources
  input wire logic             maskable_irq,
  input wire logic             halt_exec,
  input wire logic             deep_power_stop,
  input wire logic             clock_monitor_over,
  // outputs under watch
  input wire logic [NCORE-1:0] core_reset,
  input wire logic [NCORE-1:0] core_break,
  input wire logic             irq_mask,
  input wire logic             halt_mode,
  input wire logic             resume_at_reset,
  input wire logic [2:0]       irq_deliver,
  input wire logic             flash_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // ----------
  // helper logic
  // ----------
  logic dbg_cmd;
  logic brk_all;
  logic stepping;
  logic dbg_seen_reg;
  assign dbg_cmd = psel && penable && pready && pwrite && paddr == drc_pkg::CMD_OFF
                   && pwdata[drc_pkg::CMD_RESET];
  assign brk_all = &core_break;
  assign stepping = !core_break[0] && irq_mask;
  // remembers a debugger reset until its pulse ends, so user resets are told apart
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dbg_seen_reg <= 1'b0;
    end else if (dbg_cmd) begin
      dbg_seen_reg <= 1'b1;
    end else if ($fell(core_reset[0])) begin
      dbg_seen_reg <= 1'b0;
    end
  end

  // ----------
  // assertions
  // ----------
  irq_in_break_a: assert property (brk_all |-> irq_mask)
    else $error("irq unmasked in break");
  pend_served_a: assert property (irq_mask && maskable_irq ##1 !irq_mask |-> ##[0:2] irq_deliver[0])
    else $error("pending irq lost");
  dbg_rst_len_a: assert property (dbg_seen_reg && $rose(core_reset[0]) |-> core_reset[0] [*5] ##1 !core_reset[0])
    else $error("debugger reset length");
  brk_after_rst_a: assert property (dbg_seen_reg && $fell(core_reset[0]) |-> ##[0:2] brk_all)
    else $error("no break after reset");
  masked_drop_a: assert property (irq_mask && $past(irq_mask) && !dbg_cmd && !dbg_seen_reg
    && !core_reset[0] |=> !core_reset[0])
    else $error("masked reset applied");
  halt_step_a: assert property (halt_exec && stepping |-> ##[1:2] brk_all && !halt_mode)
    else $error("stepped halt not trapped");
  deep_step_a: assert property (deep_power_stop && stepping |-> ##[1:2] brk_all && resume_at_reset)
    else $error("stepped deep stop not trapped");
  monitor_stop_a: assert property (clock_monitor_over [*8] |-> !flash_busy)
    else $error("flash busy above limit");
  brk_no_halt_a: assert property (brk_all |=> !halt_mode)
    else $error("halt kept in break");
  cover property (dbg_cmd);
  cover property (halt_exec && stepping);
  cover property (deep_power_stop && stepping);
endmodule : drc_rc_monitor

bind drc_run_control drc_rc_monitor #(.NCORE(NCORE)) mon (
  .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .maskable_irq, .halt_exec, .deep_power_stop, .clock_monitor_over, .core_reset,
  .core_break, .irq_mask, .halt_mode, .resume_at_reset, .irq_deliver, .flash_busy
);
`default_nettype wire

/* File: bench/drc_cpu_model.sv */
// behavioural cpu and target-board model facing the run-control block
`timescale 1ns/10ps
`default_nettype none
module drc_cpu_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // run-control view
  input  wire logic       core_break,
  input  wire logic       irq_mask,
  // bench controls
  input  wire logic [1:0] mode,
  input  wire logic [3:0] lat,
  input  wire logic       rst_req,
  // cpu events and target pin
  output logic            step_done,
  output logic            halt_exec,
  output logic            deep_power_stop,
  output logic            pin_reset_n
);
  logic [3:0] cnt_reg;
  // the pin only drops while the program runs, never during link setup
  assign pin_reset_n = !(rst_req && !irq_mask);
  // one event per stretch out of break, lat cycles late; an endless step is not modelled
  always_ff @(posedge sys_clk) begin
    step_done <= 1'b0;
    halt_exec <= 1'b0;
    deep_power_stop <= 1'b0;
    if (!resetn || core_break) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != 4'hF) begin
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg == lat) begin
        step_done <= mode == 2'h0;
        halt_exec <= mode == 2'h1;
        deep_power_stop <= mode == 2'h2;
      end
    end
  end
endmodule : drc_cpu_model
`default_nettype wire

/* File: bench/test_debug_run_control.sv */
// self-checking bench for the debug run-control block
`timescale 1ns/10ps
`default_nettype none
module test_debug_run_control;
  localparam int NC = 2;
  // multiplier times two, index variant*4 + oscillator
  localparam logic [5:0] MULT [16] = '{6'h3C, 6'h30, 6'h28, 6'h1E, 6'h32, 6'h28, 6'h00,
    6'h19, 6'h28, 6'h20, 6'h00, 6'h14, 6'h1E, 6'h18, 6'h14, 6'h0F};
  logic          sys_clk, resetn, psel, penable, pwrite, pready, pslverr, pin_reset_n;
  logic          user_sw_reset, maskable_irq, fast_irq, float_exception_irq, err;
  logic          halt_exec, deep_power_stop, step_done, dacc_valid, dma_valid, rst_req;
  logic          clock_monitor_over, irq_mask, halt_mode, resume_at_reset, dacc_grant;
  logic          guard_error, dma_conflict, flash_clk_up, flash_busy;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, dacc_addr, dma_addr, rd;
  logic [NC-1:0] core_reset, core_break;
  logic [2:0]    irq_deliver;
  logic [5:0]    pll_mult_x2;
  logic [1:0]    mode;
  logic [3:0]    lat;
  int            compares, miscompares, n;

  drc_run_control #(.NCORE(NC)) uut (
    .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pin_reset_n, .user_sw_reset, .maskable_irq, .fast_irq,
    .float_exception_irq, .halt_exec, .deep_power_stop, .step_done, .dacc_valid,
    .dacc_addr, .dma_valid, .dma_addr, .clock_monitor_over, .core_reset, .core_break,
    .irq_mask, .halt_mode, .resume_at_reset, .irq_deliver, .dacc_grant, .guard_error,
    .dma_conflict, .pll_mult_x2, .flash_clk_up, .flash_busy
  );
  drc_cpu_model cpu (
    .sys_clk, .resetn, .core_break(core_break[0]), .irq_mask, .mode, .lat, .rst_req,
    .step_done, .halt_exec, .deep_power_stop, .pin_reset_n
  );
  always #20 sys_clk = ~sys_clk;

  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // one idle cycle after each transfer keeps strobes from being driven twice at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic cmd(input int b);
    apb(1'b1, drc_pkg::CMD_OFF, 32'h1 << b);
  endtask : cmd

  function automatic logic probe(input int k);
    case (k)
      0: return &core_break;
      1: return core_reset[0];
      2: return flash_busy;
      3: return irq_deliver == 3'h7;
      5: return !core_break[0];
      6: return halt_mode;
      default: return !core_reset[0] && !flash_busy;
    endcase
  endfunction : probe

  task automatic await_on(input int k, input int lim);
    n = 0;
    while (!probe(k) && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk(probe(k), 1'b1);
  endtask : await_on

  // only ram and guard windows are touched, none behind a gated peripheral clock
  task automatic acc(input logic dm, input logic [31:0] a, input logic g);
    dacc_valid <= !dm;
    dma_valid <= dm;
    dacc_addr <= a;
    dma_addr <= a;
    @(posedge sys_clk);
    dacc_valid <= 1'b0;
    dma_valid <= 1'b0;
    @(posedge sys_clk);
    chk(dm ? dma_conflict : dacc_grant, g);
  endtask : acc

  // ----------
  // scenarios
  // ----------
  initial begin
    sys_clk = 1'b0;
    {resetn, psel, penable, pwrite, user_sw_reset, maskable_irq, fast_irq} = '0;
    {float_exception_irq, dacc_valid, dma_valid, clock_monitor_over, rst_req} = '0;
    {paddr, pwdata, dacc_addr, dma_addr, mode, lat} = '0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(core_break, {NC{1'b1}});
    chk(irq_mask, 1'b1);
    apb(1'b0, drc_pkg::WRAM_LO_OFF, '0);
    chk(rd, drc_pkg::WRAM_LO_RST);
    apb(1'b0, drc_pkg::WRAM_HI_OFF, '0);
    chk(rd, drc_pkg::WRAM_HI_RST);
    apb(1'b0, 8'h40, '0);
    chk(err, 1'b1);
    user_sw_reset <= 1'b1;
    cmd(drc_pkg::CMD_SWRST);
    user_sw_reset <= 1'b0;
    {maskable_irq, fast_irq, float_exception_irq} <= 3'h7;
    @(posedge sys_clk);
    {fast_irq, float_exception_irq} <= 2'h0;
    repeat (3) @(posedge sys_clk);
    chk(irq_deliver, 3'h0);
    chk(core_reset, '0);
    cmd(drc_pkg::CMD_RUN);
    await_on(3, 4);
    chk(core_reset, '0);
    maskable_irq <= 1'b0;
    rst_req <= 1'b1;
    await_on(1, 8);
    rst_req <= 1'b0;
    await_on(4, 20);
    apb(1'b1, drc_pkg::CTRL_OFF, 32'h7);
    cmd(drc_pkg::CMD_RESET);
    await_on(1, 3);
    n = 0;
    while (core_reset[0] === 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, drc_pkg::RST_CYC);
    await_on(0, 3);
    for (int m = 0; m < 3; m++) begin
      mode <= 2'(m);
      lat <= 4'(m * 5);
      cmd(drc_pkg::CMD_STEP);
      await_on(5, 4);
      await_on(0, 30);
      chk(halt_mode, 1'b0);
      chk(resume_at_reset, m == 2);
    end
    mode <= 2'h1;
    cmd(drc_pkg::CMD_RUN);
    await_on(6, 20);
    cmd(drc_pkg::CMD_BREAK);
    await_on(0, 4);
    @(posedge sys_clk);
    chk(halt_mode, 1'b0);
    apb(1'b1, drc_pkg::CTRL_OFF, 32'h2);
    acc(1'b0, 32'hFFA1_0010, 1'b0);
    apb(1'b1, drc_pkg::CTRL_OFF, 32'hE);
    acc(1'b0, 32'hFFA1_0010, 1'b1);
    acc(1'b0, 32'hFFC0_0020, 1'b0);
    chk(guard_error, 1'b1);
    apb(1'b1, drc_pkg::STATUS_OFF, 32'h1);
    chk(guard_error, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, drc_pkg::CTRL_OFF, {24'h0, 2'(i % 4), 2'(i / 4), 4'h6});
      cmd(drc_pkg::CMD_FLASH);
      await_on(2, 4);
      chk(pll_mult_x2, MULT[i]);
      chk(flash_clk_up, MULT[i] != 6'h00);
      cmd(drc_pkg::CMD_FLASH);
      await_on(4, 4);
    end
    clock_monitor_over <= 1'b1;
    repeat (6) @(posedge sys_clk);
    cmd(drc_pkg::CMD_FLASH);
    repeat (2) @(posedge sys_clk);
    chk(flash_busy, 1'b0);
    clock_monitor_over <= 1'b0;
    repeat (6) @(posedge sys_clk);
    cmd(drc_pkg::CMD_FLASH);
    await_on(2, 4);
    acc(1'b1, drc_pkg::WRAM_LO_RST, 1'b1);
    acc(1'b1, drc_pkg::WRAM_HI_RST, 1'b1);
    acc(1'b1, 32'hFEBF_D9FC, 1'b0);
    clock_monitor_over <= 1'b1;
    await_on(4, 8);
    results();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    results();
  end
endmodule : test_debug_run_control
`default_nettype wire
